// ===== hw/bcr_top.sv
`timescale 1ns/1ps
`include "bcr_regs.svh"

// Notes on behaviour
// - Six byte-wide read/write control registers, index 0 to 5; slot 6 absent.
// - Registers sit on the host local bus; host is the only master.
// - Only A[29:31] select a register; map repeats through chip select.
// - Control bits act while zero; defaults leave functions inactive except both boot protects.
// - Register zero at offset 0 on D(0:7); always accessible; no upper bits.
// - Register zero reloads defaults on power-on or host hard reset.
// - Bit 0 low protects host boot sector; raise only with host unlock low.
// - Bit 1 low protects slave boot sector; raise only with slave unlock low.
// - Bit 2 low resets the framer; host hard reset also resets it.
// - Bit 3 low selects the codec for programming; default deselected.
// - Bit 4 low lights slave green LED; shows slave hard reset in config.
// - Bit 5 low lights slave red LED; shows slave soft reset in config.
// - Bit 6 low lights host green LED; shows host hard reset in config.
// - Bit 7 low lights host red LED; shows host soft reset in config.
// - Status register reports switch option, config, board and logic revs.
module bcr_top #(
    parameter logic [1:0] BOARD_CFG_CODE = 2'h1,
    parameter logic [1:0] BOARD_REV_CODE = 2'h1,
    parameter logic [1:0] LOGIC_REV_CODE = 2'h1
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Host local bus
    input wire logic TS_N,
    input wire logic CS_N,
    input wire logic RD_WR,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] D_IN,
    output logic [7:0] D_OUT,
    output logic D_OE_N,
    output logic TA_N,
    // Reset and unlock sources
    input wire logic HARD_RESET_N,
    input wire logic RESET_CONFIG_N,
    input wire logic SLAVE_HARD_RESET_N,
    input wire logic SLAVE_SOFT_RESET_N,
    input wire logic HOST_HARD_RESET_N,
    input wire logic HOST_SOFT_RESET_N,
    input wire logic HOST_BOOT_UNLOCK_N,
    input wire logic SLAVE_BOOT_UNLOCK_N,
    // Option switch
    input wire logic [1:0] SW_OPTION,
    // Board controls
    output logic HOST_BOOT_PROTECT_N,
    output logic SLAVE_BOOT_PROTECT_N,
    output logic FRAMER_RESET_N,
    output logic CODEC_SELECT_N,
    output logic SLAVE_GREEN_LED_N,
    output logic SLAVE_RED_LED_N,
    output logic HOST_GREEN_LED_N,
    output logic HOST_RED_LED_N
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int BUS_W = 14;
    localparam int BRD_W = 10;

    logic [BUS_W-1:0] bus_raw;
    logic [BUS_W-1:0] bus_s;
    logic [BRD_W-1:0] brd_raw;
    logic [BRD_W-1:0] brd_s;
    logic ts_n_s;
    logic cs_n_s;
    logic rd_wr_s;
    logic [2:0] addr_s;
    logic [7:0] d_in_s;
    logic hard_reset_n_s;
    logic reset_config_n_s;
    logic slave_hard_reset_n_s;
    logic slave_soft_reset_n_s;
    logic host_hard_reset_n_s;
    logic host_soft_reset_n_s;
    logic host_boot_unlock_n_s;
    logic slave_boot_unlock_n_s;
    logic [1:0] sw_option_s;

    // All bus lines share one latency, so address and data stay aligned
    assign bus_raw = {TS_N, CS_N, RD_WR, ADDR, D_IN};
    assign brd_raw = {HARD_RESET_N, RESET_CONFIG_N, SLAVE_HARD_RESET_N,
                      SLAVE_SOFT_RESET_N, HOST_HARD_RESET_N,
                      HOST_SOFT_RESET_N, HOST_BOOT_UNLOCK_N,
                      SLAVE_BOOT_UNLOCK_N, SW_OPTION};

    bcr_sync #(
        .W(BUS_W),
        .INIT('1)
    ) u_bus_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d(bus_raw),
        .q(bus_s)
    );

    bcr_sync #(
        .W(BRD_W),
        .INIT('1)
    ) u_brd_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d(brd_raw),
        .q(brd_s)
    );

    assign {ts_n_s, cs_n_s, rd_wr_s, addr_s, d_in_s} = bus_s;
    assign {hard_reset_n_s, reset_config_n_s, slave_hard_reset_n_s,
            slave_soft_reset_n_s, host_hard_reset_n_s, host_soft_reset_n_s,
            host_boot_unlock_n_s, slave_boot_unlock_n_s, sw_option_s} = brd_s;

    // ****************************************************************
    // State
    // ****************************************************************
    bcr_pkg::bcr_top_state_type st_reg;
    bcr_pkg::bcr_top_state_type st_next;

    logic start;
    logic [7:0] status_byte;
    logic [7:0] wdata;
    logic [7:0] ctrl0_after;
    logic [`BCR_NUM_CTRL-1:0] wr_sel;
    logic [7:0] rd_sel;
    logic [5:0][7:0] ctrl_wr;
    logic [3:0] led_sel;

    // ****************************************************************
    // Status byte
    // ****************************************************************
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`BCR_STAT_SWOPT_LSB +: 2] = sw_option_s;
        status_byte[`BCR_STAT_CFG_LSB +: 2] = BOARD_CFG_CODE;
        status_byte[`BCR_STAT_BREV_LSB +: 2] = BOARD_REV_CODE;
        status_byte[`BCR_STAT_LREV_LSB +: 2] = LOGIC_REV_CODE;
    end

    // ****************************************************************
    // Protection gating
    // ****************************************************************
    // A protect bit may only be raised while its unlock bit is low, so a
    // stray write cannot open the boot sector on its own.
    always_comb
    begin
        wdata = d_in_s;
        if (!st_reg.ctrl[0][`BCR_BIT_HOST_PROT] && host_boot_unlock_n_s)
        begin
            wdata[`BCR_BIT_HOST_PROT] = 1'b0;
        end
        if (!st_reg.ctrl[0][`BCR_BIT_SLAVE_PROT] && slave_boot_unlock_n_s)
        begin
            wdata[`BCR_BIT_SLAVE_PROT] = 1'b0;
        end
    end

    // Falling edge of the synchronised transfer start, chip selected
    assign start = st_reg.ts_prev_n && !ts_n_s && !cs_n_s;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    // Only three address lines are decoded, so the map repeats
    always_comb
    begin
        wr_sel = '0;
        rd_sel = `BCR_UNMAPPED_READ;
        for (int i = 0; i < `BCR_NUM_CTRL; i++)
        begin
            if (addr_s == 3'(i))
            begin
                wr_sel[i] = !rd_wr_s;
                rd_sel = st_reg.ctrl[i];
            end
        end
        if (addr_s == `BCR_IDX_STATUS)
        begin
            rd_sel = status_byte;
        end
    end

    // Host hard reset wins over a write in the same cycle
    always_comb
    begin
        ctrl_wr = st_reg.ctrl;
        for (int i = 0; i < `BCR_NUM_CTRL; i++)
        begin
            if (start && st_reg.state == bcr_pkg::BCR_IDLE && wr_sel[i])
            begin
                ctrl_wr[i] = (i == 0) ? wdata : d_in_s;
            end
        end
        if (!hard_reset_n_s)
        begin
            ctrl_wr[0] = `BCR_CTRL0_RESET;
            for (int i = 1; i < `BCR_NUM_CTRL; i++)
            begin
                ctrl_wr[i] = `BCR_CTRLN_RESET;
            end
        end
    end

    // ****************************************************************
    // Lamp select
    // ****************************************************************
    // Software signalling is hidden while the reset configuration runs
    always_comb
    begin
        if (!reset_config_n_s)
        begin
            led_sel[0] = slave_hard_reset_n_s;
            led_sel[1] = slave_soft_reset_n_s;
            led_sel[2] = host_hard_reset_n_s;
            led_sel[3] = host_soft_reset_n_s;
        end
        else
        begin
            led_sel[0] = ctrl_wr[0][`BCR_BIT_SLV_GREEN];
            led_sel[1] = ctrl_wr[0][`BCR_BIT_SLV_RED];
            led_sel[2] = ctrl_wr[0][`BCR_BIT_HOST_GREEN];
            led_sel[3] = ctrl_wr[0][`BCR_BIT_HOST_RED];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.ts_prev_n = ts_n_s;
        st_next.ta_n = 1'b1;
        st_next.d_oe_n = 1'b1;
        st_next.ctrl = ctrl_wr;
        unique case (st_reg.state)
            bcr_pkg::BCR_IDLE:
            begin
                if (start)
                begin
                    st_next.state = bcr_pkg::BCR_ACK;
                    st_next.ta_n = 1'b0;
                    st_next.d_oe_n = !rd_wr_s;
                    st_next.rdata = rd_sel;
                end
            end
            bcr_pkg::BCR_ACK:
            begin
                st_next.state = bcr_pkg::BCR_IDLE;
            end
        endcase

        ctrl0_after = ctrl_wr[0];
        st_next.host_prot_n = ctrl0_after[`BCR_BIT_HOST_PROT];
        st_next.slave_prot_n = ctrl0_after[`BCR_BIT_SLAVE_PROT];
        st_next.framer_n = ctrl0_after[`BCR_BIT_FRAMER_RST]
            && hard_reset_n_s;
        st_next.codec_n = ctrl0_after[`BCR_BIT_CODEC_SEL];
        st_next.led_n = led_sel;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            st_reg.state <= bcr_pkg::BCR_IDLE;
            st_reg.ts_prev_n <= 1'b1;
            st_reg.ctrl[0] <= `BCR_CTRL0_RESET;
            for (int i = 1; i < `BCR_NUM_CTRL; i++)
            begin
                st_reg.ctrl[i] <= `BCR_CTRLN_RESET;
            end
            st_reg.rdata <= 8'h00;
            st_reg.ta_n <= 1'b1;
            st_reg.d_oe_n <= 1'b1;
            st_reg.host_prot_n <= 1'b0;
            st_reg.slave_prot_n <= 1'b0;
            st_reg.framer_n <= 1'b1;
            st_reg.codec_n <= 1'b1;
            st_reg.led_n <= 4'hf;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign D_OUT = st_reg.rdata;
    assign D_OE_N = st_reg.d_oe_n;
    assign TA_N = st_reg.ta_n;
    assign HOST_BOOT_PROTECT_N = st_reg.host_prot_n;
    assign SLAVE_BOOT_PROTECT_N = st_reg.slave_prot_n;
    assign FRAMER_RESET_N = st_reg.framer_n;
    assign CODEC_SELECT_N = st_reg.codec_n;
    assign SLAVE_GREEN_LED_N = st_reg.led_n[0];
    assign SLAVE_RED_LED_N = st_reg.led_n[1];
    assign HOST_GREEN_LED_N = st_reg.led_n[2];
    assign HOST_RED_LED_N = st_reg.led_n[3];

endmodule : bcr_top

// ===== pkg/bcr_regs.svh
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH

// ****************************************************************
// Register indexes, taken from address lines A[29:31]
// ****************************************************************
`define BCR_IDX_CTRL0 3'h0
`define BCR_IDX_CTRL1 3'h1
`define BCR_IDX_CTRL2 3'h2
`define BCR_IDX_CTRL3 3'h3
`define BCR_IDX_CTRL4 3'h4
`define BCR_IDX_CTRL5 3'h5
`define BCR_IDX_SIX 3'h6
`define BCR_IDX_STATUS 3'h7
`define BCR_NUM_CTRL 6

// ****************************************************************
// Fields of board_control_zero
// ****************************************************************
`define BCR_BIT_HOST_PROT 0
`define BCR_BIT_SLAVE_PROT 1
`define BCR_BIT_FRAMER_RST 2
`define BCR_BIT_CODEC_SEL 3
`define BCR_BIT_SLV_GREEN 4
`define BCR_BIT_SLV_RED 5
`define BCR_BIT_HOST_GREEN 6
`define BCR_BIT_HOST_RED 7

// ****************************************************************
// Reset values
// ****************************************************************
`define BCR_CTRL0_RESET 8'hfc
`define BCR_CTRLN_RESET 8'hff
`define BCR_UNMAPPED_READ 8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define BCR_STAT_SWOPT_LSB 6
`define BCR_STAT_CFG_LSB 4
`define BCR_STAT_BREV_LSB 2
`define BCR_STAT_LREV_LSB 0

`endif

// ===== pkg/bcr_pkg.sv
package bcr_pkg;

    typedef enum logic {BCR_IDLE, BCR_ACK} bcr_bus_state_type;

    typedef logic [7:0] bcr_byte_type;

    typedef struct packed {
        bcr_bus_state_type state;
        logic ts_prev_n;
        logic [5:0][7:0] ctrl;
        logic [7:0] rdata;
        logic ta_n;
        logic d_oe_n;
        logic host_prot_n;
        logic slave_prot_n;
        logic framer_n;
        logic codec_n;
        logic [3:0] led_n;
    } bcr_top_state_type;

endpackage : bcr_pkg

// ===== hw/bcr_sync.sv
`timescale 1ns/1ps

module bcr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bcr_sync_state_type;

    bcr_sync_state_type st_reg;
    bcr_sync_state_type st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= {INIT, INIT};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;

endmodule : bcr_sync

// ===== verif/bcr_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Host bus master on the local bus
// ****************************************************************
module bcr_host_model (
    // Clock
    input wire logic CORE_CLK,
    // Request
    output logic TS_N,
    output logic CS_N,
    output logic RD_WR,
    output logic [2:0] ADDR,
    output logic [7:0] D_IN,
    // Answer
    input wire logic TA_N,
    input wire logic [7:0] D_OUT,
    input wire logic D_OE_N
);
    initial
    begin
        TS_N = 1'b1;
        CS_N = 1'b1;
        RD_WR = 1'b1;
        ADDR = 3'h0;
        D_IN = 8'h00;
    end

    // Sole master: holds the request until acknowledge or eight clocks, then releases
    task automatic access(input logic rd, input logic [2:0] a,
        input logic [7:0] wd, output logic [7:0] rdat, output logic oe_n,
        output bit ok);
        int n;
        ok = 1'b0;
        @(negedge CORE_CLK);
        TS_N = 1'b0;
        CS_N = 1'b0;
        RD_WR = rd;
        ADDR = a;
        D_IN = wd;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge CORE_CLK);
            ok = (TA_N === 1'b0);
        end
        rdat = D_OUT;
        oe_n = D_OE_N;
        @(negedge CORE_CLK);
        TS_N = 1'b1;
        CS_N = 1'b1;
        // Released data lines never keep the last value
        D_IN = ~wd;
        // Strobe high long enough for the input synchronisers
        repeat (3) @(negedge CORE_CLK);
    endtask : access
endmodule : bcr_host_model

// ===== verif/bcr_checker_assertions.sv
`timescale 1ns/1ps

module bcr_checker (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Bus
    input wire logic TS_N,
    input wire logic CS_N,
    input wire logic TA_N,
    input wire logic RD_WR,
    input wire logic D_OE_N,
    // Reset and unlock sources
    input wire logic HARD_RESET_N,
    input wire logic RESET_CONFIG_N,
    input wire logic SLAVE_SOFT_RESET_N,
    input wire logic HOST_HARD_RESET_N,
    input wire logic HOST_BOOT_UNLOCK_N,
    input wire logic SLAVE_BOOT_UNLOCK_N,
    // Controls
    input wire logic HOST_BOOT_PROTECT_N,
    input wire logic SLAVE_BOOT_PROTECT_N,
    input wire logic FRAMER_RESET_N,
    input wire logic CODEC_SELECT_N,
    input wire logic SLAVE_RED_LED_N,
    input wire logic HOST_GREEN_LED_N
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    ta_one_cycle_a: assert property (!TA_N |=> TA_N)
        else $error("acknowledge longer than one cycle");
    oe_read_only_a: assert property (!TA_N |-> D_OE_N == !RD_WR)
        else $error("data enable does not follow direction");
    oe_with_ack_a: assert property (!D_OE_N |-> !TA_N)
        else $error("data enabled outside acknowledge");
    ts_ack_a: assert property ($fell(TS_N) && !CS_N |-> ##[2:4] !TA_N)
        else $error("access not acknowledged in time");
    reset_defaults_a: assert property (disable iff (1'b0) RST |=> TA_N
        && !HOST_BOOT_PROTECT_N && !SLAVE_BOOT_PROTECT_N && FRAMER_RESET_N
        && CODEC_SELECT_N) else $error("outputs not at defaults in reset");
    framer_hold_a: assert property (!HARD_RESET_N [*4] |-> !FRAMER_RESET_N)
        else $error("framer not held in reset by hard reset");
    host_lock_a: assert property ((HOST_BOOT_UNLOCK_N [*4] ##0
        !HOST_BOOT_PROTECT_N) |=> !HOST_BOOT_PROTECT_N)
        else $error("host protection lifted while locked");
    slave_lock_a: assert property ((SLAVE_BOOT_UNLOCK_N [*4] ##0
        !SLAVE_BOOT_PROTECT_N) |=> !SLAVE_BOOT_PROTECT_N)
        else $error("slave protection lifted while locked");
    host_mirror_a: assert property ((!RESET_CONFIG_N
        && $stable(HOST_HARD_RESET_N)) [*4]
        |-> HOST_GREEN_LED_N == HOST_HARD_RESET_N)
        else $error("host green lamp not mirroring hard reset");
    slave_mirror_a: assert property ((!RESET_CONFIG_N
        && $stable(SLAVE_SOFT_RESET_N)) [*4]
        |-> SLAVE_RED_LED_N == SLAVE_SOFT_RESET_N)
        else $error("slave red lamp not mirroring soft reset");

    cover property ($rose(HOST_BOOT_PROTECT_N));
    cover property (!RESET_CONFIG_N && !HOST_GREEN_LED_N);
    cover property (!HARD_RESET_N && !FRAMER_RESET_N);
endmodule : bcr_checker

bind bcr_top bcr_checker chk (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .TS_N(TS_N),
    .CS_N(CS_N),
    .TA_N(TA_N),
    .RD_WR(RD_WR),
    .D_OE_N(D_OE_N),
    .HARD_RESET_N(HARD_RESET_N),
    .RESET_CONFIG_N(RESET_CONFIG_N),
    .SLAVE_SOFT_RESET_N(SLAVE_SOFT_RESET_N),
    .HOST_HARD_RESET_N(HOST_HARD_RESET_N),
    .HOST_BOOT_UNLOCK_N(HOST_BOOT_UNLOCK_N),
    .SLAVE_BOOT_UNLOCK_N(SLAVE_BOOT_UNLOCK_N),
    .HOST_BOOT_PROTECT_N(HOST_BOOT_PROTECT_N),
    .SLAVE_BOOT_PROTECT_N(SLAVE_BOOT_PROTECT_N),
    .FRAMER_RESET_N(FRAMER_RESET_N),
    .CODEC_SELECT_N(CODEC_SELECT_N),
    .SLAVE_RED_LED_N(SLAVE_RED_LED_N),
    .HOST_GREEN_LED_N(HOST_GREEN_LED_N)
);

// ===== verif/tb.sv
`timescale 1ns/1ps

module tb;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic HARD_RESET_N = 1'b1;
    logic RESET_CONFIG_N = 1'b1;
    logic [3:0] rst_lines = 4'hf;
    logic [1:0] unlock_n = 2'h3;
    logic [1:0] SW_OPTION = 2'h2;
    logic TS_N, CS_N, RD_WR, D_OE_N, TA_N;
    logic [2:0] ADDR;
    logic [7:0] D_IN, D_OUT, rd_val;
    wire [7:0] pins;
    int errors = 0;
    int checks = 0;
    bit ok;
    logic oe_seen;

    always #2 CORE_CLK = ~CORE_CLK;

    bcr_host_model host (.CORE_CLK(CORE_CLK), .TS_N(TS_N), .CS_N(CS_N),
        .RD_WR(RD_WR), .ADDR(ADDR), .D_IN(D_IN), .TA_N(TA_N), .D_OUT(D_OUT),
        .D_OE_N(D_OE_N));

    bcr_top dut (.CORE_CLK(CORE_CLK), .RST(RST), .TS_N(TS_N), .CS_N(CS_N),
        .RD_WR(RD_WR), .ADDR(ADDR), .D_IN(D_IN), .D_OUT(D_OUT),
        .D_OE_N(D_OE_N), .TA_N(TA_N), .HARD_RESET_N(HARD_RESET_N),
        .RESET_CONFIG_N(RESET_CONFIG_N), .SLAVE_HARD_RESET_N(rst_lines[0]),
        .SLAVE_SOFT_RESET_N(rst_lines[1]), .HOST_HARD_RESET_N(rst_lines[2]),
        .HOST_SOFT_RESET_N(rst_lines[3]), .HOST_BOOT_UNLOCK_N(unlock_n[0]),
        .SLAVE_BOOT_UNLOCK_N(unlock_n[1]), .SW_OPTION(SW_OPTION),
        .HOST_BOOT_PROTECT_N(pins[0]), .SLAVE_BOOT_PROTECT_N(pins[1]),
        .FRAMER_RESET_N(pins[2]), .CODEC_SELECT_N(pins[3]),
        .SLAVE_GREEN_LED_N(pins[4]), .SLAVE_RED_LED_N(pins[5]),
        .HOST_GREEN_LED_N(pins[6]), .HOST_RED_LED_N(pins[7]));

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.access(1'b0, a, d, rd_val, oe_seen, ok);
        check("write ack", {7'h0, ok}, 8'h01);
        check("write oe", {7'h0, oe_seen}, 8'h01);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        host.access(1'b1, a, 8'h00, rd_val, oe_seen, ok);
        check("read ack", {7'h0, ok}, 8'h01);
        check("read oe", {7'h0, oe_seen}, 8'h00);
        check("read data", rd_val, exp);
    endtask : rd

    task automatic give_verdict;
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Whole sequence needs well under 20 us
    initial
    begin
        #40000;
        errors++;
        give_verdict();
    end

    initial
    begin
        repeat (4) @(negedge CORE_CLK);
        RST = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        check("pins", pins, 8'hfc);
        rd(3'h0, 8'hfc);
        wr(3'h0, 8'h03);
        rd(3'h0, 8'h00);
        check("pins", pins, 8'h00);
        unlock_n = 2'h2;
        repeat (3) @(negedge CORE_CLK);
        wr(3'h0, 8'h01);
        rd(3'h0, 8'h01);
        unlock_n = 2'h1;
        repeat (3) @(negedge CORE_CLK);
        wr(3'h0, 8'h03);
        rd(3'h0, 8'h03);
        unlock_n = 2'h3;
        check("pins", pins, 8'h03);
        for (int i = 1; i < 6; i++)
            wr(i[2:0], 8'h30 + i[7:0]);
        for (int i = 1; i < 6; i++)
            rd(i[2:0], 8'h30 + i[7:0]);
        wr(3'h6, 8'h5a);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h95);
        wr(3'h0, 8'h5c);
        check("pins", pins, 8'h5c);
        HARD_RESET_N = 1'b0;
        repeat (5) @(negedge CORE_CLK);
        check("pins", pins, 8'hf8);
        HARD_RESET_N = 1'b1;
        repeat (4) @(negedge CORE_CLK);
        rd(3'h0, 8'hfc);
        RESET_CONFIG_N = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            rst_lines = i[0] ? 4'h9 : 4'h6;
            repeat (5) @(negedge CORE_CLK);
            check("lamps", {4'h0, pins[7:4]}, {4'h0, rst_lines});
        end
        RESET_CONFIG_N = 1'b1;
        give_verdict();
    end
endmodule : tb
